// ==== tac_top.sv ====
// thermal alert configuration register with serial bus slave
`timescale 1ns/100ps
`include "tac_consts.svh"
`default_nettype none
module tac_top
    import tac_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [10:0] temp_i,
    input  wire logic        temp_valid_i,
    output logic             sensor_sleep_o,
    output logic             alert_o,
    output logic             alert_oe_o
);
    logic        scl_s1, scl_s2, scl_s3;
    logic        sda_s1, sda_s2, sda_s3;
    logic        scl_rise, scl_fall, bus_start, bus_stop;
    tac_state_t  state_r;
    logic [3:0]  bitcnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  tx_r;
    logic [7:0]  ptr_r;
    logic [1:0]  idx_r;
    logic        rw_r, nack_r, lsb_r, wr_stb_r;
    logic [15:0] wdata_r;
    logic [7:0]  rx_byte;
    logic [15:0] rd_word;
    logic [1:0]  hyst_r;
    logic        sleep_r, clock_r, wlock_r;
    logic        out_en_r, crit_only_r, pol_r, mode_r;
    logic        any_lock, cfg_wr, release_c;
    logic [10:0] lim_r [3];
    logic [2:0]  above;
    logic [10:0] temp_r;
    logic [5:0]  hyst_val;
    logic        up_a, lo_a, crit_a, cond_c, cond_d_r, pend_r;
    logic        asserted_c, alert_state_r;

    default clocking tac_cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_i};
            {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_i};
        end
    end

    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    assign rx_byte   = {sh_r[6:0], sda_s2};

    // serial slave: address, pointer, then msb and lsb of the word
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r  <= TAC_IDLE;
            bitcnt_r <= 4'h0;
            sh_r     <= 8'h00;
            tx_r     <= 8'h00;
            ptr_r    <= `TAC_PTR_RESET;
            idx_r    <= 2'h0;
            rw_r     <= 1'b0;
            nack_r   <= 1'b0;
            lsb_r    <= 1'b0;
            wr_stb_r <= 1'b0;
            wdata_r  <= 16'h0000;
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (bus_start) begin
                state_r  <= TAC_ADDR;
                bitcnt_r <= 4'h0;
                idx_r    <= 2'h0;
                sda_oe_o <= 1'b0;
            end else if (bus_stop) begin
                state_r  <= TAC_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state_r)
                    TAC_ADDR, TAC_RX: begin
                        if (scl_rise) begin
                            sh_r     <= rx_byte;
                            bitcnt_r <= bitcnt_r + 4'h1;
                            if (bitcnt_r == 4'h7) begin
                                bitcnt_r <= 4'h0;
                                if (state_r == TAC_ADDR) begin
                                    rw_r    <= sda_s2;
                                    lsb_r   <= 1'b0;
                                    state_r <= (rx_byte[7:1] == `TAC_DEV_ADDR)
                                               ? TAC_ACK : TAC_IDLE;
                                end else begin
                                    state_r <= TAC_ACK;
                                    if (idx_r == 2'h0) begin
                                        ptr_r <= rx_byte;
                                    end else if (idx_r == 2'h1) begin
                                        wdata_r[15:8] <= rx_byte;
                                    end else begin
                                        wdata_r[7:0] <= rx_byte;
                                        wr_stb_r     <= 1'b1;
                                    end
                                    if (idx_r != 2'h2) begin
                                        idx_r <= idx_r + 2'h1;
                                    end else begin
                                        idx_r <= 2'h1;
                                    end
                                end
                            end
                        end
                    end
                    TAC_ACK: begin
                        if (scl_fall && !sda_oe_o) begin
                            sda_o    <= 1'b0;
                            sda_oe_o <= 1'b1;
                        end else if (scl_fall) begin
                            if (rw_r) begin
                                state_r  <= TAC_TX;
                                tx_r     <= rd_word[15:8];
                                sda_o    <= rd_word[15];
                            end else begin
                                state_r  <= TAC_RX;
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                    TAC_TX: begin
                        if (scl_rise) begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && bitcnt_r == 4'h8) begin
                            bitcnt_r <= 4'h0;
                            sda_oe_o <= 1'b0;
                            state_r  <= TAC_RACK;
                        end else if (scl_fall && bitcnt_r != 4'h0) begin
                            tx_r  <= {tx_r[6:0], 1'b0};
                            sda_o <= tx_r[6];
                        end
                    end
                    TAC_RACK: begin
                        if (scl_rise) begin
                            nack_r <= sda_s2;
                        end else if (scl_fall) begin
                            if (nack_r) begin
                                state_r <= TAC_IDLE;
                            end else begin
                                state_r  <= TAC_TX;
                                lsb_r    <= ~lsb_r;
                                tx_r <= lsb_r ? rd_word[15:8] : rd_word[7:0];
                                sda_o    <= lsb_r ? rd_word[15] : rd_word[7];
                                sda_oe_o <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign any_lock  = clock_r | wlock_r;
    assign cfg_wr    = wr_stb_r && ptr_r == `TAC_PTR_CFG;
    // relies on host: upper bits of wdata are simply not stored
    assign release_c = cfg_wr && wdata_r[`TAC_BIT_RELEASE] && mode_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            {hyst_r, sleep_r, clock_r, wlock_r} <= 5'h00;
            {out_en_r, crit_only_r, pol_r, mode_r} <= 4'h0;
        end else if (cfg_wr) begin
            if (!any_lock) begin
                hyst_r   <= wdata_r[`TAC_BIT_HYST_HI:`TAC_BIT_HYST_LO];
                sleep_r  <= wdata_r[`TAC_BIT_SLEEP];
                out_en_r <= wdata_r[`TAC_BIT_OUT_EN];
                pol_r    <= wdata_r[`TAC_BIT_POL];
                mode_r   <= wdata_r[`TAC_BIT_MODE];
            end
            if (!wlock_r) begin
                crit_only_r <= wdata_r[`TAC_BIT_CRIT_ONLY];
            end
            clock_r <= clock_r | wdata_r[`TAC_BIT_CLOCK];
            wlock_r <= wlock_r | wdata_r[`TAC_BIT_WLOCK];
        end
    end

    // trip points held in the form of bits 12:2
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lim_r[0] <= 11'h000;
            lim_r[1] <= 11'h000;
            lim_r[2] <= 11'h000;
        end else if (wr_stb_r) begin
            if (ptr_r == `TAC_PTR_UPPER && !wlock_r) begin
                lim_r[0] <= wdata_r[12:2];
            end
            if (ptr_r == `TAC_PTR_LOWER && !wlock_r) begin
                lim_r[1] <= wdata_r[12:2];
            end
            if (ptr_r == `TAC_PTR_CRIT && !clock_r) begin
                lim_r[2] <= wdata_r[12:2];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            temp_r <= 11'h000;
        end else if (temp_valid_i && !sleep_r) begin
            temp_r <= temp_i;
        end
    end

    always_comb begin
        case (hyst_r)
            2'h1:    hyst_val = `TAC_HYST_1;
            2'h2:    hyst_val = `TAC_HYST_2;
            2'h3:    hyst_val = `TAC_HYST_3;
            default: hyst_val = `TAC_HYST_0;
        endcase
    end

    // lower limit counts as above once temperature meets it
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_lim
            tac_limit_cmp #(.INCL(g == 1)) u_cmp (
                .mclk_i  (mclk_i),
                .rst_i   (rst_i),
                .temp_i  (temp_r),
                .limit_i (lim_r[g]),
                .hyst_i  (hyst_val),
                .above_o (above[g])
            );
        end
    endgenerate

    assign up_a   = above[0];
    assign lo_a   = ~above[1];
    assign crit_a = above[2];
    assign cond_c = crit_only_r ? crit_a : (up_a | lo_a | crit_a);

    // pending flag: a new trip in the release cycle wins
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cond_d_r <= 1'b0;
            pend_r   <= 1'b0;
        end else begin
            cond_d_r <= cond_c;
            pend_r   <= (cond_c & ~cond_d_r) | (pend_r & ~release_c);
        end
    end

    assign asserted_c = out_en_r & ~sleep_r
                      & (mode_r ? pend_r : cond_c);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            alert_state_r  <= 1'b0;
            alert_o        <= 1'b1;
            alert_oe_o     <= 1'b0;
            sensor_sleep_o <= 1'b0;
        end else begin
            alert_state_r  <= asserted_c;
            alert_o        <= pol_r ? asserted_c : ~asserted_c;
            alert_oe_o     <= ~sleep_r;
            sensor_sleep_o <= sleep_r;
        end
    end

    always_comb begin
        case (ptr_r)
            `TAC_PTR_CFG:   rd_word = {5'h00, hyst_r, sleep_r, clock_r,
                                       wlock_r, 1'b0, alert_state_r,
                                       out_en_r, crit_only_r, pol_r,
                                       mode_r};
            `TAC_PTR_UPPER: rd_word = {3'h0, lim_r[0], 2'h0};
            `TAC_PTR_LOWER: rd_word = {3'h0, lim_r[1], 2'h0};
            `TAC_PTR_CRIT:  rd_word = {3'h0, lim_r[2], 2'h0};
            `TAC_PTR_TEMP:  rd_word = {crit_a, up_a, lo_a, temp_r, 2'h0};
            default:        rd_word = 16'h0000;
        endcase
    end

    cfg_read_zero_a: assert property (
        ptr_r == `TAC_PTR_CFG |-> rd_word[15:11] == 5'h00 && !rd_word[5])
        else $error("reserved or release bit reads nonzero");
    crit_lock_a: assert property (clock_r |=> clock_r)
        else $error("critical lock cleared");
    win_lock_a: assert property (wlock_r |=> wlock_r)
        else $error("window lock cleared");
    locked_fields_a: assert property (
        cfg_wr && any_lock |=> $stable(hyst_r) && $stable(sleep_r)
                               && $stable(mode_r) && $stable(pol_r))
        else $error("locked field changed");
    crit_refuse_a: assert property (
        clock_r |=> $stable(lim_r[2]))
        else $error("critical trip changed under lock");
    win_refuse_a: assert property (
        wlock_r |=> $stable(lim_r[0]) && $stable(lim_r[1]))
        else $error("window trip changed under lock");
    sleep_quiet_a: assert property (
        sleep_r |=> !alert_oe_o && !alert_state_r && $stable(temp_r))
        else $error("activity during sleep");
    release_a: assert property (
        release_c && !(cond_c && !cond_d_r) |=> !pend_r)
        else $error("release did not free alert");
    out_gate_a: assert property (
        !out_en_r |=> !alert_state_r)
        else $error("alert with output disabled");
    polarity_a: assert property (
        alert_state_r |-> alert_o == $past(pol_r))
        else $error("alert level wrong for polarity");

    cfg_write_c: cover property (cfg_wr);
    release_c_c: cover property (pend_r ##1 release_c ##1 !pend_r);
    sleep_c: cover property ($rose(sleep_r));
    read_tx_c: cover property (state_r == TAC_RACK && ptr_r == `TAC_PTR_CFG);
endmodule
`default_nettype wire

// ==== tac_consts.svh ====
// register offsets, field positions and constants of the thermal alert block
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

`define TAC_PTR_CFG        8'h01
`define TAC_PTR_UPPER      8'h02
`define TAC_PTR_LOWER      8'h03
`define TAC_PTR_CRIT       8'h04
`define TAC_PTR_TEMP       8'h05

// bus address, value is arbitrary
`define TAC_DEV_ADDR       7'h18

`define TAC_CFG_RESET      16'h0000
`define TAC_PTR_RESET      8'h00

`define TAC_BIT_HYST_HI    10
`define TAC_BIT_HYST_LO    9
`define TAC_BIT_SLEEP      8
`define TAC_BIT_CLOCK      7
`define TAC_BIT_WLOCK      6
`define TAC_BIT_RELEASE    5
`define TAC_BIT_OUT_EN     3
`define TAC_BIT_CRIT_ONLY  2
`define TAC_BIT_POL        1
`define TAC_BIT_MODE       0

// hysteresis in quarter degrees: 0, 1.5, 3.0, 6.0
`define TAC_HYST_0         6'h00
`define TAC_HYST_1         6'h06
`define TAC_HYST_2         6'h0c
`define TAC_HYST_3         6'h18

`endif

// ==== tac_pkg.sv ====
// types of the thermal alert block
package tac_pkg;
    typedef enum logic [2:0] {
        TAC_IDLE = 3'b000,
        TAC_ADDR = 3'b001,
        TAC_ACK  = 3'b011,
        TAC_RX   = 3'b010,
        TAC_TX   = 3'b110,
        TAC_RACK = 3'b111
    } tac_state_t;
endpackage

// ==== tac_limit_cmp.sv ====
// one trip point comparator with falling-edge hysteresis
`timescale 1ns/100ps
`default_nettype none
module tac_limit_cmp #(
    parameter bit INCL = 1'b0
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [10:0] temp_i,
    input  wire logic [10:0] limit_i,
    input  wire logic [5:0]  hyst_i,
    output logic             above_o
);
    logic signed [11:0] temp_s;
    logic signed [11:0] lim_s;
    logic signed [11:0] lim_low;
    logic               set_c;
    logic               clr_c;
    logic               above_r;

    assign temp_s  = {temp_i[10], temp_i};
    assign lim_s   = {limit_i[10], limit_i};
    assign lim_low = lim_s - $signed({6'h00, hyst_i});
    assign set_c   = INCL ? (temp_s >= lim_s) : (temp_s > lim_s);
    assign clr_c   = temp_s < lim_low;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            above_r <= 1'b0;
        end else if (set_c) begin
            above_r <= 1'b1;
        end else if (clr_c) begin
            above_r <= 1'b0;
        end
    end

    assign above_o = above_r;
endmodule
`default_nettype wire

// ==== tac_host_model.sv ====
// two-wire bus host model driving the block's serial port
`timescale 1ns/100ps
`include "tac_consts.svh"
`default_nettype none
module tac_host_model (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // open-drain SDA: only ever pulls low, pull-up gives the high level; SCL is driven both ways
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // also serves as repeated start after an ack bit
    task automatic start_cond();
        sda_low_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
        tick(2);
    endtask

    task automatic stop_cond();
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b0;
        tick(4);
    endtask

    // drive mid low phase, sample mid high phase; slave answers ~3 mclk late
    task automatic bit_xfer(input logic b, output logic s);
        sda_low_o <= ~b;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        s = sda_i;
        tick(2);
        scl_o <= 1'b0;
        tick(2);
    endtask

    task automatic byte_out(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], s);
        bit_xfer(1'b1, ack_n);
    endtask

    task automatic byte_in(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(last, s);
    endtask

    task automatic write_word(input logic [6:0] dev, input logic [7:0] ptr,
                              input logic [15:0] d, output logic nak);
        logic        a0, a1, a2, a3;
        logic [15:0] w;
        w = (ptr == `TAC_PTR_CFG) ? (d & 16'h07ff) : d;
        start_cond();
        byte_out({dev, 1'b0}, a0);
        byte_out(ptr, a1);
        byte_out(w[15:8], a2);
        byte_out(w[7:0], a3);
        stop_cond();
        nak = a0 | a1 | a2 | a3;
    endtask

    task automatic read_word(input logic [7:0] ptr, output logic [15:0] d);
        logic       a;
        logic [7:0] hi, lo;
        start_cond();
        byte_out({`TAC_DEV_ADDR, 1'b0}, a);
        byte_out(ptr, a);
        start_cond();
        byte_out({`TAC_DEV_ADDR, 1'b1}, a);
        byte_in(1'b0, hi);
        byte_in(1'b1, lo);
        stop_cond();
        d = {hi, lo};
    endtask
endmodule
`default_nettype wire

// ==== test_thermal_alert_config_register.sv ====
// self-checking bench for the thermal alert control register
`timescale 1ns/100ps
`include "tac_consts.svh"
`default_nettype none
module test_thermal_alert_config_register;
    logic        mclk, rst, scl, sda_w, sda_o, sda_oe, host_low;
    logic [10:0] temp;
    logic        temp_vld, sleep, alert, alert_oe, nak;
    logic [15:0] rd;
    int          n_errors = 0;
    int          n_tests = 0;
    localparam logic [10:0] UPPER = 11'd340;
    logic [5:0]  hy [4] = '{6'd0, 6'd6, 6'd12, 6'd24};

    always #2 mclk = ~mclk;
    assign sda_w = ~((sda_oe & ~sda_o) | host_low);

    tac_top dut (.mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .temp_i(temp),
        .temp_valid_i(temp_vld), .sensor_sleep_o(sleep),
        .alert_o(alert), .alert_oe_o(alert_oe));
    tac_host_model host (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl),
        .sda_low_o(host_low));

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        host.write_word(`TAC_DEV_ADDR, p, d, nak);
        check("write ack", {15'h0, nak}, 16'h0000);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] p,
                          input logic [15:0] exp);
        host.read_word(p, rd);
        check(name, rd, exp);
    endtask

    task automatic set_temp(input logic [10:0] t);
        @(posedge mclk);
        temp <= t;
        temp_vld <= 1'b1;
        @(posedge mclk);
        temp_vld <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    task automatic pin(input string name, input logic exp);
        check(name, {15'h0, alert}, {15'h0, exp});
    endtask

    // watchdog: whole run needs roughly 16000 cycles
    initial begin
        repeat (80000) @(posedge mclk);
        n_errors++;
        summarize();
    end

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        temp = 11'd0;
        temp_vld = 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk("cfg reset", 8'h01, 16'h0000);
        check("sleep reset", {15'h0, sleep}, 16'h0000);
        // bit 4 and bit 5 written as one, neither may read back
        wr(8'h01, 16'hf93f);
        rd_chk("cfg rw", 8'h01, 16'h010f);
        check("sleep on", {15'h0, sleep}, 16'h0001);
        check("pin released", {15'h0, alert_oe}, 16'h0000);
        wr(8'h01, 16'h0000);
        rd_chk("cfg clear", 8'h01, 16'h0000);
        host.write_word(`TAC_DEV_ADDR ^ 7'h01, 8'h01, 16'h0008, nak);
        check("foreign addr", {15'h0, nak}, 16'h0001);
        rd_chk("cfg kept", 8'h01, 16'h0000);
        wr(8'h02, {3'h0, UPPER, 2'h0});
        wr(8'h04, 16'h0780);
        for (int k = 0; k < 4; k++) begin
            wr(8'h01, {5'h0, k[1:0], 9'h00a});
            set_temp(UPPER + 11'd1);
            pin("above", 1'b1);
            set_temp(UPPER - {5'h0, hy[k]});
            pin("in band", 1'b1);
            set_temp(UPPER - {5'h0, hy[k]} - 11'd1);
            pin("below band", 1'b0);
        end
        set_temp(UPPER + 11'd1);
        rd_chk("alert state", 8'h01, 16'h061a);
        rd_chk("upper flag", 8'h05, 16'h4554);
        wr(8'h01, 16'h002a);
        pin("release ignored", 1'b1);
        set_temp(11'd100);
        pin("comparator clear", 1'b0);
        wr(8'h01, 16'h000b);
        // drop any trip latched while still in comparator mode
        wr(8'h01, 16'h002b);
        pin("int idle", 1'b0);
        set_temp(UPPER + 11'd1);
        pin("int set", 1'b1);
        set_temp(11'd100);
        pin("int held", 1'b1);
        wr(8'h01, 16'h000b);
        pin("zero no effect", 1'b1);
        wr(8'h01, 16'h002b);
        pin("int released", 1'b0);
        rd_chk("release reads 0", 8'h01, 16'h000b);
        wr(8'h01, 16'h0009);
        pin("low idle", 1'b1);
        wr(8'h01, 16'h0008);
        set_temp(UPPER + 11'd1);
        pin("active low", 1'b0);
        wr(8'h01, 16'h0000);
        pin("output off", 1'b1);
        wr(8'h01, 16'h000e);
        pin("crit only", 1'b0);
        set_temp(11'd481);
        pin("crit trip", 1'b1);
        wr(8'h01, 16'h010e);
        check("sleep set", {15'h0, sleep}, 16'h0001);
        check("oe off", {15'h0, alert_oe}, 16'h0000);
        set_temp(11'd100);
        host.read_word(8'h05, rd);
        check("frozen temp", {5'h0, rd[12:2]}, 16'd481);
        rd_chk("state asleep", 8'h01, 16'h010e);
        wr(8'h01, 16'h000e);
        check("oe back", {15'h0, alert_oe}, 16'h0001);
        set_temp(11'd100);
        pin("resumed", 1'b0);
        wr(8'h01, 16'h000a);
        wr(8'h03, 16'h0320);
        pin("lower trip", 1'b1);
        rd_chk("lower flag", 8'h05, 16'h2190);
        set_temp(11'd200);
        pin("lower clear", 1'b0);
        wr(8'h01, 16'h004e);
        wr(8'h01, 16'h0701);
        rd_chk("window locked", 8'h01, 16'h004e);
        wr(8'h02, 16'h0100);
        rd_chk("upper locked", 8'h02, 16'h0550);
        wr(8'h03, 16'h0100);
        rd_chk("lower locked", 8'h03, 16'h0320);
        wr(8'h04, 16'h0400);
        rd_chk("crit open", 8'h04, 16'h0400);
        wr(8'h01, 16'h00ce);
        wr(8'h04, 16'h0200);
        rd_chk("crit locked", 8'h04, 16'h0400);
        wr(8'h01, 16'h0000);
        rd_chk("locks stay", 8'h01, 16'h00ce);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk("locks reset", 8'h01, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
